// File: common/wdt_bus_if.sv
`timescale 1ns/1ps
interface wdt_bus_if;
   logic req;
   logic write;
   logic word;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic [7:0] rdata;
   logic standby;
   logic source_clear;
   logic ovf_irq;
   logic nmi_req;
   logic chip_reset;
   logic reset_source_indicator;

   modport device (
      input req, write, word, addr, wdata, standby, source_clear,
      output ack, rdata, ovf_irq, nmi_req, chip_reset, reset_source_indicator
   );
   modport host (
      output req, write, word, addr, wdata, standby, source_clear,
      input ack, rdata, ovf_irq, nmi_req, chip_reset, reset_source_indicator
   );
endinterface : wdt_bus_if

// File: common/wdt_pkg.sv
package wdt_pkg;
   // -------------------------------------------------------------
   // Device bus map
   // -------------------------------------------------------------
   localparam logic [15:0] WRITE_ADDR = 16'hFFAA;
   localparam logic [15:0] READ_CONTROL_ADDR = 16'hFFA8;
   localparam logic [15:0] READ_COUNTER_ADDR = 16'hFFA9;
   localparam logic [7:0] PASSWORD_COUNTER = 8'h5A;
   localparam logic [7:0] PASSWORD_CONTROL = 8'hA5;
   localparam logic [7:0] CONTROL_RESET = 8'h10;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [7:0] COUNTER_MAX = 8'hFF;
   localparam logic [7:0] READ_DEFAULT = 8'h00;

   // -------------------------------------------------------------
   // Control/status field positions
   // -------------------------------------------------------------
   localparam int FLAG_BIT = 7;
   localparam int MODE_BIT = 6;
   localparam int ENABLE_BIT = 5;
   localparam int FIXED_ONE_BIT = 4;
   localparam int ACTION_BIT = 3;
   localparam int SELECT_MSB = 2;
   localparam int SELECT_LSB = 0;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int DIVIDER_WIDTH = 12;
   localparam logic [9:0] CHIP_RESET_CYCLES = 10'd518;
   localparam logic [9:0] CHIP_RESET_LAST = 10'd1;
   localparam logic [9:0] CHIP_RESET_IDLE = 10'd0;

   // -------------------------------------------------------------
   // Controller APB map
   // -------------------------------------------------------------
   localparam logic [7:0] APB_COMMAND = 8'h00;
   localparam logic [7:0] APB_WRITE_DATA = 8'h04;
   localparam logic [7:0] APB_STATUS = 8'h08;
   localparam logic [7:0] APB_SYSTEM_CONTROL = 8'h0C;
   localparam int CMD_WRITE_BIT = 16;
   localparam int CMD_WORD_BIT = 17;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DATA_LSB = 8;
   localparam int ST_OVF_BIT = 16;
   localparam int ST_NMI_BIT = 17;
   localparam int ST_RESET_BIT = 18;
   localparam int ST_SOURCE_BIT = 19;
   localparam int SYS_STANDBY_BIT = 0;
   localparam int SYS_SOURCE_CLEAR_BIT = 1;

   // Mask of low divider bits that must all be one for a tick
   function automatic logic [DIVIDER_WIDTH-1:0] divider_mask(input logic [2:0] sel);
      unique case (sel)
         3'h0: divider_mask = 12'h001;
         3'h1: divider_mask = 12'h01F;
         3'h2: divider_mask = 12'h03F;
         3'h3: divider_mask = 12'h07F;
         3'h4: divider_mask = 12'h0FF;
         3'h5: divider_mask = 12'h1FF;
         3'h6: divider_mask = 12'h7FF;
         3'h7: divider_mask = 12'hFFF;
      endcase
   endfunction : divider_mask
endpackage : wdt_pkg

// File: rtl/watchdog_bus_controller.sv
`timescale 1ns/1ps
module watchdog_bus_controller
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Watchdog side
   wdt_bus_if.host bus
);

   logic busy;
   logic [7:0] last_rdata;
   logic ovf_seen;
   logic nmi_seen;
   logic apb_write;
   logic apb_read;
   logic [31:0] next_prdata;

   assign apb_write = psel && penable && pready && pwrite;
   assign apb_read = psel && penable && !pready && !pwrite;

   always_comb begin
      next_prdata = '0;
      unique case (paddr)
         APB_COMMAND: begin
            next_prdata[15:0] = bus.addr;
            next_prdata[CMD_WRITE_BIT] = bus.write;
            next_prdata[CMD_WORD_BIT] = bus.word;
         end
         APB_WRITE_DATA: next_prdata[15:0] = bus.wdata;
         APB_STATUS: begin
            next_prdata[ST_BUSY_BIT] = busy;
            next_prdata[ST_DATA_LSB +: 8] = last_rdata;
            next_prdata[ST_OVF_BIT] = ovf_seen;
            next_prdata[ST_NMI_BIT] = nmi_seen;
            next_prdata[ST_RESET_BIT] = bus.chip_reset;
            next_prdata[ST_SOURCE_BIT] = bus.reset_source_indicator;
         end
         APB_SYSTEM_CONTROL: next_prdata[SYS_STANDBY_BIT] = bus.standby;
         default: next_prdata = '0;
      endcase
   end

   // -------------------------------------------------------------
   // APB handshake: one wait state
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= 1'b0;
         if (apb_read) begin
            prdata <= next_prdata;
         end
      end
   end

   // -------------------------------------------------------------
   // Command registers and transfer launch
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.addr <= '0;
         bus.write <= 1'b0;
         bus.word <= 1'b0;
         bus.wdata <= '0;
         bus.req <= 1'b0;
         busy <= 1'b0;
         last_rdata <= '0;
      end else begin
         bus.req <= 1'b0;
         if (apb_write && paddr == APB_WRITE_DATA && !busy) begin
            bus.wdata <= pwdata[15:0];
         end
         if (apb_write && paddr == APB_COMMAND && !busy) begin
            bus.addr <= pwdata[15:0];
            bus.write <= pwdata[CMD_WRITE_BIT];
            bus.word <= pwdata[CMD_WORD_BIT]; // R09
            bus.req <= 1'b1;
            busy <= 1'b1;
         end else if (busy && bus.ack) begin
            busy <= 1'b0;
            last_rdata <= bus.rdata;
         end
      end
   end

   // -------------------------------------------------------------
   // Event capture and system control
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_seen <= 1'b0;
         nmi_seen <= 1'b0;
      end else begin
         if (bus.ovf_irq) begin
            ovf_seen <= 1'b1;
         end else if (apb_write && paddr == APB_STATUS && pwdata[ST_OVF_BIT]) begin
            ovf_seen <= 1'b0;
         end
         if (bus.nmi_req) begin
            nmi_seen <= 1'b1;
         end else if (apb_write && paddr == APB_STATUS && pwdata[ST_NMI_BIT]) begin
            nmi_seen <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.standby <= 1'b0;
         bus.source_clear <= 1'b0;
      end else begin
         bus.source_clear <= apb_write && paddr == APB_SYSTEM_CONTROL
                             && pwdata[SYS_SOURCE_CLEAR_BIT];
         if (apb_write && paddr == APB_SYSTEM_CONTROL) begin
            bus.standby <= pwdata[SYS_STANDBY_BIT];
         end
      end
   end

endmodule : watchdog_bus_controller

// File: rtl/watchdog_interval_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Enabled counter ticks up; wrap sets flag
// R02 - Counter zero and stopped while disabled
// R03 - Flag cleared by zero write after reading one
// R04 - Bit 6 picks interval or watchdog mode
// R05 - Bit 3 picks interrupt or chip reset
// R06 - Bit 4 reads one, writes ignored
// R07 - Three select bits pick eight dividers
// R08 - Standby clears bits 7-5, 3; keeps select
// R09 - Master writes registers with word accesses only
// R10 - Shared write address; high byte is password
// R11 - Byte reads at two separate addresses
// R12 - Watchdog reset lasts 518 clock cycles
// R13 - Software rewrites counter before overflow
// R14 - Interval mode requests on every wrap
// R15 - Flag set with the overflow action
// R16 - Counter write beats simultaneous tick
// R17 - Stop counter before changing select bits
// R18 - Standby recovery resets all but select
// R19 - Reset source indication separates watchdog reset
// R20 - Mode and enable bits start operation
// R21 - Bad password or byte write ignored
// R22 - Free-running divider gives one-cycle ticks
module watchdog_interval_timer
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // CPU side
   wdt_bus_if.device bus,
   // State seen by the chip
   output logic running,
   output logic overflow_seen
);

   logic [7:0] watchdog_counter;
   logic overflow_flag;
   logic mode_select;
   logic count_enable;
   logic reset_action;
   logic [2:0] prescaler_select;
   logic flag_read_one;
   logic [DIVIDER_WIDTH-1:0] divider;
   logic [9:0] reset_count;
   logic tick;
   logic word_write;
   logic counter_write;
   logic control_write;
   logic control_read;
   logic overflow_event;
   logic reset_start;
   logic [7:0] control_image;

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   assign word_write = bus.req && bus.write && bus.word && (bus.addr == WRITE_ADDR); // R09 R21
   assign counter_write = word_write && (bus.wdata[15:8] == PASSWORD_COUNTER); // R10
   assign control_write = word_write && (bus.wdata[15:8] == PASSWORD_CONTROL); // R10
   assign control_read = bus.req && !bus.write && (bus.addr == READ_CONTROL_ADDR);
   assign tick = (divider & divider_mask(prescaler_select)) == divider_mask(prescaler_select); // R07
   assign overflow_event = count_enable && tick && !counter_write
                           && (watchdog_counter == COUNTER_MAX); // R01 R16
   assign reset_start = overflow_event && mode_select && reset_action; // R05

   always_comb begin
      control_image = CONTROL_RESET;
      control_image[FLAG_BIT] = overflow_flag;
      control_image[MODE_BIT] = mode_select;
      control_image[ENABLE_BIT] = count_enable;
      control_image[FIXED_ONE_BIT] = 1'b1; // R06
      control_image[ACTION_BIT] = reset_action;
      control_image[SELECT_MSB:SELECT_LSB] = prescaler_select;
   end

   // -------------------------------------------------------------
   // Prescaler
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divider <= '0;
      end else begin
         divider <= divider + 1'b1; // R22
      end
   end

   // -------------------------------------------------------------
   // Counter
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_counter <= COUNTER_RESET;
      end else if (bus.standby || !count_enable) begin
         watchdog_counter <= COUNTER_RESET; // R02 R18
      end else if (counter_write) begin
         watchdog_counter <= bus.wdata[7:0]; // R16
      end else if (tick) begin
         watchdog_counter <= watchdog_counter + 1'b1; // R01 R14
      end
   end

   // -------------------------------------------------------------
   // Control bits
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_select <= CONTROL_RESET[MODE_BIT];
         count_enable <= CONTROL_RESET[ENABLE_BIT];
         reset_action <= CONTROL_RESET[ACTION_BIT];
      end else if (bus.standby) begin
         mode_select <= CONTROL_RESET[MODE_BIT]; // R08 R18
         count_enable <= CONTROL_RESET[ENABLE_BIT];
         reset_action <= CONTROL_RESET[ACTION_BIT];
      end else if (control_write) begin
         mode_select <= bus.wdata[MODE_BIT]; // R04 R20
         count_enable <= bus.wdata[ENABLE_BIT]; // R20
         reset_action <= bus.wdata[ACTION_BIT]; // R05
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler_select <= CONTROL_RESET[SELECT_MSB:SELECT_LSB];
      end else if (control_write && !bus.standby) begin
         prescaler_select <= bus.wdata[SELECT_MSB:SELECT_LSB]; // R08 R17
      end
   end

   // -------------------------------------------------------------
   // Overflow flag
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= CONTROL_RESET[FLAG_BIT];
      end else if (bus.standby) begin
         overflow_flag <= CONTROL_RESET[FLAG_BIT]; // R08
      end else if (overflow_event) begin
         overflow_flag <= 1'b1; // R01 R15
      end else if (control_write && !bus.wdata[FLAG_BIT] && flag_read_one) begin
         overflow_flag <= 1'b0; // R03
      end
   end

   // Arms the clear once software has seen the flag at one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_read_one <= 1'b0;
      end else if (bus.standby || (control_write && !bus.wdata[FLAG_BIT])) begin
         flag_read_one <= 1'b0; // R03
      end else if (control_read && overflow_flag) begin
         flag_read_one <= 1'b1; // R03
      end
   end

   // -------------------------------------------------------------
   // Overflow actions
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.ovf_irq <= 1'b0;
         bus.nmi_req <= 1'b0;
      end else begin
         bus.ovf_irq <= overflow_event && !mode_select; // R04 R14 R15
         bus.nmi_req <= overflow_event && mode_select && !reset_action; // R05 R15
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_count <= CHIP_RESET_IDLE;
         bus.chip_reset <= 1'b0;
      end else if (reset_start) begin
         reset_count <= CHIP_RESET_CYCLES; // R12
         bus.chip_reset <= 1'b1; // R15
      end else begin
         if (reset_count != CHIP_RESET_IDLE) begin
            reset_count <= reset_count - 1'b1;
         end
         bus.chip_reset <= reset_count > CHIP_RESET_LAST; // R12
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.reset_source_indicator <= 1'b0;
      end else if (reset_start) begin
         bus.reset_source_indicator <= 1'b1; // R19
      end else if (bus.source_clear) begin
         bus.reset_source_indicator <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Read answer
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.ack <= 1'b0;
         bus.rdata <= READ_DEFAULT;
      end else begin
         bus.ack <= bus.req;
         if (bus.req && !bus.write && bus.addr == READ_CONTROL_ADDR) begin
            bus.rdata <= control_image; // R11
         end else if (bus.req && !bus.write && bus.addr == READ_COUNTER_ADDR) begin
            bus.rdata <= watchdog_counter; // R11
         end else begin
            bus.rdata <= READ_DEFAULT;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running <= 1'b0;
         overflow_seen <= 1'b0;
      end else begin
         running <= count_enable;
         overflow_seen <= overflow_flag;
      end
   end

endmodule : watchdog_interval_timer

// File: verif/watchdog_interval_timer_bench.sv
`timescale 1ns/1ps
module watchdog_interval_timer_bench
   import wdt_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, running, overflow_seen;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   int error_cnt, compares, cyc;
   int div[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

   wdt_bus_if link ();
   watchdog_interval_timer watchdog_interval_timer_i (.pclk(pclk), .presetn(presetn),
      .bus(link.device), .running(running), .overflow_seen(overflow_seen));
   watchdog_bus_controller watchdog_bus_controller_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link.host));
   wdt_link_checker wdt_link_checker_i (.pclk(pclk), .presetn(presetn), .req(link.req),
      .write(link.write), .word(link.word), .addr(link.addr), .wdata(link.wdata),
      .ack(link.ack), .rdata(link.rdata), .standby(link.standby),
      .source_clear(link.source_clear), .ovf_irq(link.ovf_irq), .nmi_req(link.nmi_req),
      .chip_reset(link.chip_reset), .reset_source_indicator(link.reset_source_indicator));

   always #2.5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;

   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      chk(32'({pready, pslverr}), 32'h2);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic dev(input logic w, input logic wd, input logic [15:0] a,
         input logic [15:0] d, output logic [7:0] r);
      logic [31:0] s;
      int n;
      if (w) apb(1'b1, APB_WRITE_DATA, {16'h0000, d}, s);
      apb(1'b1, APB_COMMAND, {14'h0000, wd, w, a}, s);
      n = 0;
      do begin
         apb(1'b0, APB_STATUS, 32'h0, s);
         n++;
      end while (s[ST_BUSY_BIT] !== 1'b0 && n < 20);
      chk(32'(s[ST_BUSY_BIT]), 32'h0);
      r = s[ST_DATA_LSB +: 8];
   endtask : dev

   task automatic wr(input logic [15:0] d);
      logic [7:0] r;
      dev(1'b1, 1'b1, WRITE_ADDR, d, r);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] r;
      dev(1'b0, 1'b0, a, 16'h0000, r);
      chk({24'h000000, r}, {24'h000000, e});
   endtask : rd

   // Waits for an event line (0 interval, 1 nmi, 2 chip reset) to reach a level
   task automatic wait_for(input int k, input logic lvl, output int t);
      logic v;
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         v = (k == 0) ? link.ovf_irq : (k == 1) ? link.nmi_req : link.chip_reset;
         n++;
      end while (v !== lvl && n < 20000);
      t = cyc;
      chk(32'(v), 32'(lvl));
      @(posedge pclk);
   endtask : wait_for

   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   task automatic t_reset_vals();
      rd(READ_CONTROL_ADDR, 8'h10);
      rd(READ_COUNTER_ADDR, 8'h00);
      rd(WRITE_ADDR, 8'h00);
      chk(32'({running, overflow_seen}), 32'h0);
   endtask : t_reset_vals

   task automatic t_password();
      logic [31:0] s;
      logic [7:0] r;
      apb(1'b0, 8'h10, 32'h0, s);
      chk(s, 32'h0);
      wr(16'h5A33);
      rd(READ_COUNTER_ADDR, 8'h00);
      wr(16'hA5FF);
      rd(READ_CONTROL_ADDR, 8'h7F);
      wr(16'h1200);
      rd(READ_CONTROL_ADDR, 8'h7F);
      dev(1'b1, 1'b0, WRITE_ADDR, 16'hA500, r);
      rd(READ_CONTROL_ADDR, 8'h7F);
      wr(16'h5A33);
      dev(1'b0, 1'b0, READ_COUNTER_ADDR, 16'h0000, r);
      chk(32'(r inside {8'h33, 8'h34}), 32'h1);
      wr(16'hA500);
      rd(READ_COUNTER_ADDR, 8'h00);
   endtask : t_password

   task automatic t_prescale();
      int t1, t2;
      for (int s = 0; s < 8; s++) begin
         wr(16'hA500);
         wr({8'hA5, 5'h04, s[2:0]});
         // Watch from before the load so a fast first wrap is not missed
         fork
            wr(16'h5AFF);
            wait_for(0, 1'b1, t1);
         join
         if (s > 0) wr(16'h5AFF);
         wait_for(0, 1'b1, t2);
         chk(t2 - t1, (s > 0) ? div[s] : 256 * div[s]);
      end
   endtask : t_prescale

   task automatic t_flag();
      wr(16'hA527);
      rd(READ_CONTROL_ADDR, 8'hB7);
      wr(16'hA5A7);
      rd(READ_CONTROL_ADDR, 8'hB7);
      wr(16'hA527);
      rd(READ_CONTROL_ADDR, 8'h37);
   endtask : t_flag

   task automatic t_nmi();
      logic [31:0] s;
      int t;
      wr(16'hA500);
      wr(16'hA560);
      // Refresh for longer than one full wrap at the fastest rate
      repeat (50) wr(16'h5A00);
      apb(1'b0, APB_STATUS, 32'h0, s);
      chk(32'(s[ST_NMI_BIT:ST_OVF_BIT]), 32'h1);
      wr(16'h5AFF);
      wait_for(1, 1'b1, t);
      rd(READ_CONTROL_ADDR, 8'hF0);
      chk(32'({running, overflow_seen}), 32'h3);
      apb(1'b0, APB_STATUS, 32'h0, s);
      chk(32'(s[ST_NMI_BIT:ST_OVF_BIT]), 32'h3);
   endtask : t_nmi

   task automatic t_standby();
      logic [31:0] s;
      wr(16'hA500);
      wr(16'hA52B);
      wr(16'h5A40);
      apb(1'b1, APB_SYSTEM_CONTROL, 32'h1, s);
      rd(READ_CONTROL_ADDR, 8'h13);
      rd(READ_COUNTER_ADDR, 8'h00);
      wr(16'hA520);
      rd(READ_CONTROL_ADDR, 8'h13);
      apb(1'b1, APB_SYSTEM_CONTROL, 32'h0, s);
      rd(READ_CONTROL_ADDR, 8'h13);
   endtask : t_standby

   task automatic t_chip_reset();
      logic [31:0] s;
      int t1, t2;
      wr(16'hA500);
      wr(16'hA56F);
      wr(16'h5AFF);
      wait_for(2, 1'b1, t1);
      wait_for(2, 1'b0, t2);
      chk(t2 - t1, 518);
      apb(1'b0, APB_STATUS, 32'h0, s);
      chk(32'(s[ST_SOURCE_BIT:ST_RESET_BIT]), 32'h2);
      apb(1'b1, APB_SYSTEM_CONTROL, 32'h2, s);
      apb(1'b0, APB_STATUS, 32'h0, s);
      chk(32'(s[ST_SOURCE_BIT]), 32'h0);
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset_vals();
   endtask : t_chip_reset

   task automatic close_out();
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cyc = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset_vals();
      t_password();
      t_prescale();
      t_flag();
      t_nmi();
      t_standby();
      t_chip_reset();
      close_out();
   end

   initial begin
      repeat (100000) @(posedge pclk);
      error_cnt++;
      close_out();
   end
endmodule : watchdog_interval_timer_bench

// File: verif/wdt_link_checker.sv
`timescale 1ns/1ps
module wdt_link_checker
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link signals
   input wire logic req,
   input wire logic write,
   input wire logic word,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata,
   input wire logic standby,
   input wire logic source_clear,
   input wire logic ovf_irq,
   input wire logic nmi_req,
   input wire logic chip_reset,
   input wire logic reset_source_indicator
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ------------------------------------------
   // Length of the chip reset
   // ------------------------------------------
   logic [9:0] high_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_cnt <= CHIP_RESET_IDLE;
      end else if (chip_reset) begin
         high_cnt <= high_cnt + 10'h001;
      end else begin
         high_cnt <= CHIP_RESET_IDLE;
      end
   end

   // ------------------------------------------
   // Properties
   // ------------------------------------------
   property p_ack_next;
      req |=> ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after req");
   property p_rd_fixed;
      req && !write && addr == READ_CONTROL_ADDR |=> ack && rdata[FIXED_ONE_BIT];
   endproperty
   a_rd_fixed: assert property (p_rd_fixed) else $error("fixed bit not one");
   property p_rd_none;
      req && !write && addr == WRITE_ADDR |=> ack && rdata == READ_DEFAULT;
   endproperty
   a_rd_none: assert property (p_rd_none) else $error("write address readable");
   property p_rst_len;
      $fell(chip_reset) |-> high_cnt == CHIP_RESET_CYCLES;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("chip reset length wrong");
   property p_rst_max;
      chip_reset |-> high_cnt < CHIP_RESET_CYCLES;
   endproperty
   a_rst_max: assert property (p_rst_max) else $error("chip reset too long");
   property p_src;
      $rose(chip_reset) |-> reset_source_indicator;
   endproperty
   a_src: assert property (p_src) else $error("reset source not marked");
   property p_excl;
      ovf_irq |-> !nmi_req && !chip_reset;
   endproperty
   a_excl: assert property (p_excl) else $error("two overflow actions");
   property p_irq_pulse;
      ovf_irq |=> !ovf_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interval request too long");
   property p_stby_cnt;
      standby && $past(standby) && req && !write && addr == READ_COUNTER_ADDR
         |=> rdata == COUNTER_RESET;
   endproperty
   a_stby_cnt: assert property (p_stby_cnt) else $error("counter runs in standby");
   property p_stby_ctl;
      standby && $past(standby) && req && !write && addr == READ_CONTROL_ADDR
         |=> rdata[FLAG_BIT:ENABLE_BIT] == 3'h0 && !rdata[ACTION_BIT];
   endproperty
   a_stby_ctl: assert property (p_stby_ctl) else $error("control kept in standby");

   c_irq: cover property (ovf_irq);
   c_nmi: cover property (nmi_req);
   c_rst: cover property ($fell(chip_reset));
   c_stby: cover property (standby && req);
endmodule : wdt_link_checker
